// [rtl/btu_addr_enc.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Address shortening against the previously sent address
// ****************************************************************
module btu_addr_enc (
	input  wire logic [31:0] cur,
	input  wire logic [31:0] prev,
	output var  logic [1:0]  code,
	output var  logic [3:0]  nibs,
	output var  logic [31:0] field
);

	// Longest matching prefix wins, giving the shortest field
	// shortest field chosen
	always_comb begin
		if (cur[31:btu_pkg::SHORT_BITS-1] == prev[31:btu_pkg::SHORT_BITS-1]) begin
			code  = btu_pkg::CODE_5;
			nibs  = 4'h2;
			field = cur & 32'h0000_001F;
		end else if (cur[31:btu_pkg::MID_BITS-1] == prev[31:btu_pkg::MID_BITS-1]) begin
			code  = btu_pkg::CODE_9;
			nibs  = 4'h3;
			field = cur & 32'h0000_01FF;
		end else if (cur[31:btu_pkg::LONG_BITS-1] == prev[31:btu_pkg::LONG_BITS-1]) begin
			code  = btu_pkg::CODE_17;
			nibs  = 4'h5;
			field = cur & 32'h0001_FFFF;
		end else begin
			code  = btu_pkg::CODE_32;
			nibs  = 4'h8;
			field = cur;
		end
	end

endmodule

`default_nettype wire

// [rtl/btu_pkg.sv]
package btu_pkg;

	// ****************************************************************
	// Register offsets (byte addresses on the APB)
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_HIST_IDX  = 8'h08;
	localparam logic [7:0] OFS_HIST_SRC  = 8'h0C;
	localparam logic [7:0] OFS_HIST_DST  = 8'h10;
	localparam logic [7:0] OFS_HIST_INSN = 8'h14;
	localparam logic [7:0] OFS_START_SRC = 8'h18;
	localparam logic [7:0] OFS_START_DST = 8'h1C;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_RT_BIT   = 1;
	localparam int CTRL_CONT_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_PEND_BIT   = 1;
	localparam int ST_RT_BIT     = 2;
	localparam int ST_CONT_BIT   = 3;
	localparam int ST_DROP_LSB   = 8;
	localparam int ST_COUNT_LSB  = 16;

	// ****************************************************************
	// Trace geometry
	// ****************************************************************
	localparam int HIST_DEPTH  = 8;
	localparam int HIST_AW     = 3;
	localparam int KEEP_BITS   = 28;
	localparam int SHORT_BITS  = 5;
	localparam int MID_BITS    = 9;
	localparam int LONG_BITS   = 17;
	localparam int MATCH_SHORT = 28;
	localparam int MATCH_MID   = 24;
	localparam int MATCH_LONG  = 16;
	localparam int FRAME_BITS  = 100;
	localparam int INSN_NIBS   = 8;

	// Length codes in the frame header
	localparam logic [1:0] CODE_5  = 2'h0;
	localparam logic [1:0] CODE_9  = 2'h1;
	localparam logic [1:0] CODE_17 = 2'h2;
	localparam logic [1:0] CODE_32 = 2'h3;

	typedef enum logic {
		BTU_L_IDLE,
		BTU_L_SEND
	} btu_link_state_e;

endpackage

// [rtl/btu_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two flip-flop level synchroniser
// ****************************************************************
module btu_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output var  logic q
);

	logic meta;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b0;
			q    <= 1'b0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

`default_nettype wire

// [rtl/btu_trace.sv]
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module btu_trace (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        br_valid,
	input  wire logic [31:0] br_src,
	input  wire logic [31:0] br_dst,
	input  wire logic [31:0] br_insn,
	output var  logic        cpu_stall,
	input  wire logic        run_start,
	input  wire logic [31:0] run_prev_end,
	input  wire logic [31:0] run_start_addr,
	output var  logic        trace_buf_continue,
	input  wire logic        trace_port_clock,
	output var  logic [3:0]  trace_output_port,
	output var  logic        trace_out_valid,
	output var  logic        trace_out_frame
);

	// ****************************************************************
	// Registers and CPU-side state
	// ****************************************************************
	logic [2:0]  ctrl;
	logic        act_rt;
	logic        act_cont;
	logic [2:0]  hist_idx;
	logic [27:0] hist_src  [btu_pkg::HIST_DEPTH];
	logic [27:0] hist_dst  [btu_pkg::HIST_DEPTH];
	logic [31:0] hist_insn [btu_pkg::HIST_DEPTH];
	logic [2:0]  hist_wp;
	logic [3:0]  hist_cnt;
	logic [27:0] start_src;
	logic [27:0] start_dst;
	logic [7:0]  drop_cnt;
	logic        req_tog;
	logic        pend;
	logic [31:0] pend_src, pend_dst, pend_insn;
	logic [31:0] mb_src, mb_dst, mb_insn;
	logic        ack_s, done_s;
	logic        trace_on, outstanding, mb_free, accept, idle;
	logic [2:0]  rd_slot;

	// Link-side state
	logic        link_rst_n;
	logic        req_s, req_seen, ack_tog, done_tog;
	logic [31:0] sent_src, sent_dst;
	btu_pkg::btu_link_state_e lstate;
	logic [31:0] prev_src, prev_dst, cur_src, cur_dst;
	logic [btu_pkg::FRAME_BITS-1:0] shreg;
	logic [4:0]  nib_left;
	logic        first_nib;
	logic        cap, finish;
	logic [1:0]  src_code, dst_code;
	logic [3:0]  src_nibs, dst_nibs;
	logic [31:0] src_field, dst_field;
	logic [btu_pkg::FRAME_BITS-1:0] frame;
	logic [4:0]  total_n;

	// Decodes an APB offset into a known register
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= btu_pkg::OFS_START_DST) && (a[1:0] == 2'b00);
	endfunction

	// ****************************************************************
	// APB slave
	// ****************************************************************
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);

	// Control and index writes, taken in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= btu_pkg::CTRL_RESET;
			hist_idx <= 3'h0;
		end else if (psel && penable && pwrite) begin
			if (paddr == btu_pkg::OFS_CTRL) begin
				ctrl <= pwdata[2:0];
			end
			if (paddr == btu_pkg::OFS_HIST_IDX) begin
				hist_idx <= pwdata[2:0];
			end
		end
	end

	// Index 0 is the newest branch
	assign rd_slot = 3'(hist_wp - 3'h1 - hist_idx);

	// Read data latched in the setup phase so the access phase answers at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (paddr)
				btu_pkg::OFS_CTRL:      prdata <= {29'h0, ctrl};
				btu_pkg::OFS_STATUS:    prdata <= {12'h0, hist_cnt, drop_cnt, 4'h0,
					act_cont, act_rt, pend, outstanding};
				btu_pkg::OFS_HIST_IDX:  prdata <= {29'h0, hist_idx};
				btu_pkg::OFS_HIST_SRC:  prdata <= {4'h0, hist_src[rd_slot]};
				btu_pkg::OFS_HIST_DST:  prdata <= {4'h0, hist_dst[rd_slot]};
				btu_pkg::OFS_HIST_INSN: prdata <= hist_insn[rd_slot];
				btu_pkg::OFS_START_SRC: prdata <= {4'h0, start_src};
				btu_pkg::OFS_START_DST: prdata <= {4'h0, start_dst};
				default:                prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// Branch acceptance and stall
	// ****************************************************************
	assign trace_on    = ctrl[btu_pkg::CTRL_EN_BIT];
	assign outstanding = req_tog ^ done_s;
	assign mb_free     = (req_tog == ack_s);
	assign idle        = !outstanding && !pend;
	// in non-realtime mode, hold the CPU while a record is unfinished
	assign cpu_stall   = br_valid && trace_on && !act_rt && (outstanding || pend);
	assign accept      = br_valid && trace_on && !cpu_stall;
	assign trace_buf_continue = act_cont;

	// modes only change between records, so a frame never mixes them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_rt   <= 1'b0;
			act_cont <= 1'b0;
		end else if (idle && !accept) begin
			act_rt   <= ctrl[btu_pkg::CTRL_RT_BIT];
			act_cont <= ctrl[btu_pkg::CTRL_CONT_BIT];
		end
	end

	// ****************************************************************
	// Internal history
	// ****************************************************************
	// eight-entry ring, oldest overwritten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_wp  <= 3'h0;
			hist_cnt <= 4'h0;
		end else if (accept) begin
			hist_wp  <= 3'(hist_wp + 3'h1);
			hist_cnt <= (hist_cnt == 4'(btu_pkg::HIST_DEPTH)) ? hist_cnt : 4'(hist_cnt + 4'h1);
		end
	end

	// Ring storage; only the low bits of the addresses are kept
	always_ff @(posedge pclk) begin
		if (accept) begin
			hist_src[hist_wp]  <= br_src[btu_pkg::KEEP_BITS-1:0];
			hist_dst[hist_wp]  <= br_dst[btu_pkg::KEEP_BITS-1:0];
			hist_insn[hist_wp] <= br_insn;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_src <= 28'h000_0000;
			start_dst <= 28'h000_0000;
		end else if (run_start && trace_on) begin
			start_src <= run_prev_end[btu_pkg::KEEP_BITS-1:0];
			start_dst <= run_start_addr[btu_pkg::KEEP_BITS-1:0];
		end
	end

	// ****************************************************************
	// Hand-off toward the trace port
	// ****************************************************************
	// a waiting record is replaced by a newer one, counted as lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_tog  <= 1'b0;
			pend     <= 1'b0;
			drop_cnt <= 8'h00;
		end else if (mb_free && (accept || pend)) begin
			req_tog  <= !req_tog;
			pend     <= 1'b0;
			drop_cnt <= (accept && pend) ? 8'(drop_cnt + 8'h01) : drop_cnt;
		end else if (accept) begin
			pend     <= 1'b1;
			drop_cnt <= pend ? 8'(drop_cnt + 8'h01) : drop_cnt;
		end
	end

	// Mailbox words stay frozen while the link side may read them
	always_ff @(posedge pclk) begin
		if (mb_free && accept) begin
			mb_src  <= br_src;
			mb_dst  <= br_dst;
			mb_insn <= br_insn;
		end else if (mb_free && pend) begin
			mb_src  <= pend_src;
			mb_dst  <= pend_dst;
			mb_insn <= pend_insn;
		end
		if (!mb_free && accept) begin
			pend_src  <= br_src;
			pend_dst  <= br_dst;
			pend_insn <= br_insn;
		end
	end

	// Link toggles back into the CPU domain
	btu_sync u_ack_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (ack_tog),
		.q     (ack_s)
	);

	btu_sync u_done_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (done_tog),
		.q     (done_s)
	);

	// ****************************************************************
	// Trace port domain
	// ****************************************************************
	// Reset release retimed to the port clock
	btu_sync u_rst_sync (
		.clk   (trace_port_clock),
		.rst_n (presetn),
		.d     (1'b1),
		.q     (link_rst_n)
	);

	btu_sync u_req_sync (
		.clk   (trace_port_clock),
		.rst_n (presetn),
		.d     (req_tog),
		.q     (req_s)
	);

	assign cap     = (req_s != req_seen);
	assign cur_src = mb_src;
	assign cur_dst = mb_dst;

	// each kind against its own previous value
	btu_addr_enc u_src_enc (
		.cur   (cur_src),
		.prev  (prev_src),
		.code  (src_code),
		.nibs  (src_nibs),
		.field (src_field)
	);

	btu_addr_enc u_dst_enc (
		.cur   (cur_dst),
		.prev  (prev_dst),
		.code  (dst_code),
		.nibs  (dst_nibs),
		.field (dst_field)
	);

	// header, destination, source, then destination instruction
	always_comb begin
		frame = {96'h0, dst_code, src_code};
		frame = frame | ({68'h0, dst_field} << 4);
		frame = frame | ({68'h0, src_field} << (7'(4) + {1'b0, dst_nibs, 2'b00}));
		frame = frame | ({68'h0, mb_insn} << (7'(4) + {1'b0, dst_nibs, 2'b00}
			+ {1'b0, src_nibs, 2'b00}));
		total_n = 5'(5'd1 + {1'b0, dst_nibs} + {1'b0, src_nibs} + 5'(btu_pkg::INSN_NIBS));
	end

	assign finish = (lstate == btu_pkg::BTU_L_SEND) && (nib_left == 5'h01) && !cap;

	// a new capture restarts the frame; the old one is closed unsent
	always_ff @(posedge trace_port_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lstate    <= btu_pkg::BTU_L_IDLE;
			req_seen  <= 1'b0;
			ack_tog   <= 1'b0;
			done_tog  <= 1'b0;
			shreg     <= '0;
			nib_left  <= 5'h00;
			first_nib <= 1'b0;
		end else begin
			case (lstate)
				btu_pkg::BTU_L_IDLE: begin
					if (cap) begin
						lstate <= btu_pkg::BTU_L_SEND;
					end
				end
				btu_pkg::BTU_L_SEND: begin
					if (finish) begin
						lstate <= btu_pkg::BTU_L_IDLE;
					end
				end
				default: lstate <= btu_pkg::BTU_L_IDLE;
			endcase
			if (cap) begin
				req_seen  <= req_s;
				ack_tog   <= !ack_tog;
				shreg     <= frame;
				nib_left  <= total_n;
				first_nib <= 1'b1;
				if (lstate == btu_pkg::BTU_L_SEND) begin
					done_tog <= !done_tog;
				end
			end else if (lstate == btu_pkg::BTU_L_SEND) begin
				shreg     <= shreg >> 4;
				nib_left  <= 5'(nib_left - 5'h01);
				first_nib <= 1'b0;
				if (finish) begin
					done_tog <= !done_tog;
				end
			end
		end
	end

	// Mailbox may already hold a newer record when a frame ends,
	// so the pair being sent is kept on this side of the crossing
	// reference moves only once a frame went out whole
	always_ff @(posedge trace_port_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			sent_src <= 32'h0000_0000;
			sent_dst <= 32'h0000_0000;
			prev_src <= 32'h0000_0000;
			prev_dst <= 32'h0000_0000;
		end else begin
			if (cap) begin
				sent_src <= cur_src;
				sent_dst <= cur_dst;
			end
			if (finish) begin
				prev_src <= sent_src;
				prev_dst <= sent_dst;
			end
		end
	end

	// Port pins from flops
	always_ff @(posedge trace_port_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			trace_output_port <= 4'h0;
			trace_out_valid   <= 1'b0;
			trace_out_frame   <= 1'b0;
		end else begin
			trace_output_port <= (lstate == btu_pkg::BTU_L_SEND && !cap) ? shreg[3:0] : 4'h0;
			trace_out_valid   <= (lstate == btu_pkg::BTU_L_SEND) && !cap;
			trace_out_frame   <= (lstate == btu_pkg::BTU_L_SEND) && !cap && first_nib;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_hist_depth: assert property (
		@(posedge pclk) disable iff (!presetn)
		accept |=> hist_cnt == (($past(hist_cnt) == 4'h8) ? 4'h8 : $past(hist_cnt) + 4'h1))
		else $error("history count wrong");
	a_start_record: assert property (
		@(posedge pclk) disable iff (!presetn)
		(run_start && trace_on) |=> start_src == $past(run_prev_end[27:0])
			&& start_dst == $past(run_start_addr[27:0]))
		else $error("start record not taken");
	a_upper_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && paddr == btu_pkg::OFS_HIST_DST) |=> prdata[31:28] == 4'h0)
		else $error("upper address bits kept");
	a_frame_start: assert property (
		@(posedge trace_port_clock) disable iff (!link_rst_n)
		(cap && lstate == btu_pkg::BTU_L_IDLE) ##1 !cap |=> trace_out_frame && trace_out_valid)
		else $error("frame header missing");
	a_prev_follow: assert property (
		@(posedge trace_port_clock) disable iff (!link_rst_n)
		finish |=> prev_dst == $past(sent_dst) && prev_src == $past(sent_src))
		else $error("reference not updated");
	a_short_code: assert property (
		@(posedge trace_port_clock) disable iff (!link_rst_n)
		(cap && cur_dst[31:4] == prev_dst[31:4]) |=> shreg[3:2] == btu_pkg::CODE_5)
		else $error("short code not chosen");
	a_rt_restart: assert property (
		@(posedge trace_port_clock) disable iff (!link_rst_n)
		(cap && lstate == btu_pkg::BTU_L_SEND) |=> nib_left == $past(total_n) && first_nib)
		else $error("frame not restarted");
	a_rt_no_stall: assert property (
		@(posedge pclk) disable iff (!presetn)
		act_rt |-> !cpu_stall)
		else $error("realtime stalled");
	a_nrt_stall: assert property (
		@(posedge pclk) disable iff (!presetn)
		(br_valid && trace_on && !act_rt && outstanding) |-> cpu_stall ##0 !accept)
		else $error("no stall while busy");
	a_cfg_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		(outstanding || pend) |=> $stable(act_rt) && $stable(act_cont))
		else $error("mode changed while busy");

	c_frame_done: cover property (@(posedge trace_port_clock) disable iff (!link_rst_n) finish);
	c_abandon: cover property (@(posedge trace_port_clock) disable iff (!link_rst_n)
		cap && lstate == btu_pkg::BTU_L_SEND);
	c_stall: cover property (@(posedge pclk) disable iff (!presetn) cpu_stall);
	c_start: cover property (@(posedge pclk) disable iff (!presetn) run_start && trace_on);

endmodule

`default_nettype wire

// [verification/btu_acq.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Acquisition side: frame decode, address rebuild, trace store
// ****************************************************************
module btu_acq #(
	parameter int DEPTH = 4
) (
	input  wire logic        trace_port_clock,
	input  wire logic        rst_n,
	input  wire logic [3:0]  nib,
	input  wire logic        valid,
	input  wire logic        frame,
	input  wire logic        cont,
	output var  logic [3:0]  last_hdr,
	output var  logic [31:0] last_src,
	output var  logic [31:0] last_dst,
	output var  logic [31:0] last_insn,
	output var  logic [15:0] frames
);
	logic [95:0] acc;
	logic [95:0] full;
	logic [3:0]  hdr;
	logic [4:0]  k;
	logic [4:0]  dn;
	logic [4:0]  sn;
	logic        done;
	logic [31:0] store [DEPTH];
	int          wp;
	int          cnt;

	function automatic logic [4:0] nibs_of(input logic [1:0] c);
		return (c == 2'h0) ? 5'h2 : (c == 2'h1) ? 5'h3 : (c == 2'h2) ? 5'h5 : 5'h8;
	endfunction

	// full address from a shortened field
	function automatic logic [31:0] rebuild(input logic [31:0] p, input logic [1:0] c,
			input logic [31:0] f);
		logic [31:0] m;
		m = (c == 2'h0) ? 32'h0000_001F : (c == 2'h1) ? 32'h0000_01FF :
			(c == 2'h2) ? 32'h0001_FFFF : 32'hFFFF_FFFF;
		return (p & ~m) | (f & m);
	endfunction

	// Frame geometry; a drop of valid mid-frame discards the partial record
	assign dn = nibs_of(hdr[3:2]);
	assign sn = nibs_of(hdr[1:0]);
	assign full = acc | ({92'h0, nib} << (4 * (k - 5'h1)));
	assign done = valid && !frame && (k != 5'h0) && (k == dn + sn + 5'h8);

	// Nibble collection; references only move on complete frames
	always_ff @(posedge trace_port_clock or negedge rst_n) begin
		if (!rst_n) begin
			k <= 5'h0;
			acc <= '0;
			hdr <= 4'h0;
			last_hdr <= 4'h0;
			last_src <= 32'h0000_0000;
			last_dst <= 32'h0000_0000;
			last_insn <= 32'h0000_0000;
			frames <= 16'h0000;
		end else if (!valid) begin
			k <= 5'h0;
		end else if (frame) begin
			hdr <= nib;
			acc <= '0;
			k <= 5'h1;
		end else if (k != 5'h0) begin
			acc <= full;
			k <= k + 5'h1;
			if (done) begin
				k <= 5'h0;
				last_hdr <= hdr;
				last_dst <= rebuild(last_dst, hdr[3:2], full[31:0]);
				last_src <= rebuild(last_src, hdr[1:0], 32'(full >> (4 * dn)));
				last_insn <= 32'(full >> (4 * (dn + sn)));
				frames <= frames + 16'h0001;
			end
		end
	end

	// full store: overwrite oldest or keep the first ones
	always_ff @(posedge trace_port_clock or negedge rst_n) begin
		if (!rst_n) begin
			wp <= 0;
			cnt <= 0;
		end else if (done && (cnt < DEPTH || cont)) begin
			store[wp] <= 32'(full >> (4 * (dn + sn)));
			wp <= (wp + 1) % DEPTH;
			cnt <= (cnt < DEPTH) ? cnt + 1 : cnt;
		end
	end
endmodule

`default_nettype wire

// [verification/btu_trace_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module btu_trace_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        br_valid;
	logic [31:0] br_src;
	logic [31:0] br_dst;
	logic [31:0] br_insn;
	logic        cpu_stall;
	logic        run_start;
	logic [31:0] run_prev_end;
	logic [31:0] run_start_addr;
	logic        cont;
	logic        lclk;
	logic [3:0]  nib;
	logic        lvalid;
	logic        lframe;
	logic [3:0]  hdr;
	logic [31:0] a_src;
	logic [31:0] a_dst;
	logic [31:0] a_insn;
	logic [15:0] frames;
	logic [31:0] d;
	logic        err_st;
	int          miscompares;
	int          total_checks;
	int          stalls;
	logic [31:0] s_tab [3] = '{32'h8000_1200, 32'h8000_1210, 32'h8000_1214};
	logic [31:0] d_tab [3] = '{32'h8000_1230, 32'h8000_5670, 32'h8000_567C};
	logic [3:0]  h_tab [3] = '{4'hF, 4'h9, 4'h0};

	btu_trace dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .br_valid(br_valid), .br_src(br_src), .br_dst(br_dst),
		.br_insn(br_insn), .cpu_stall(cpu_stall), .run_start(run_start),
		.run_prev_end(run_prev_end), .run_start_addr(run_start_addr),
		.trace_buf_continue(cont), .trace_port_clock(lclk), .trace_output_port(nib),
		.trace_out_valid(lvalid), .trace_out_frame(lframe));

	btu_acq acq (.trace_port_clock(lclk), .rst_n(presetn), .nib(nib), .valid(lvalid),
		.frame(lframe), .cont(cont), .last_hdr(hdr), .last_src(a_src), .last_dst(a_dst),
		.last_insn(a_insn), .frames(frames));

	// Clocks; link clock free running and unrelated in phase
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// port clock under the 60 MHz ceiling
	initial begin
		lclk = 1'b0;
		#7;
		forever #32 lclk = ~lclk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus cycle; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Answer taken at the rising edge that sees pready high
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, wd, r, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r, exp);
		chk({31'h0, e}, {31'h0, experr});
	endtask

	// Branch held while stalled; entered just after an edge
	task automatic branch(input logic [31:0] s, input logic [31:0] dd);
		logic st;
		br_valid <= 1'b1;
		br_src <= s;
		br_dst <= dd;
		br_insn <= ~dd;
		do begin
			@(negedge pclk);
			st = cpu_stall;
			stalls += int'(st === 1'b1);
			@(posedge pclk);
		end while (st === 1'b1);
	endtask

	task automatic wait_frames(input logic [15:0] n);
		int i;
		i = 0;
		while (frames !== n && i < 400) begin
			@(posedge pclk);
			i++;
		end
		chk({16'h0, frames}, {16'h0, n});
	endtask

	// Watchdog
	initial begin
		#3_000_000;
		miscompares++;
		close_out();
	end

	initial begin
		{psel, penable, pwrite, br_valid, run_start} = 5'h0;
		{paddr, pwdata, br_src, br_dst, br_insn, run_prev_end, run_start_addr} = '0;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rd_chk(btu_pkg::OFS_CTRL, 32'h0000_0000, 1'b0); // idle after reset
		rd_chk(btu_pkg::OFS_STATUS, 32'h0000_0000, 1'b0); // empty history
		rd_chk(8'h20, 32'h0000_0000, 1'b1); // unmapped refused
		wr(btu_pkg::OFS_STATUS, 32'hFFFF_FFFF); // status read only
		rd_chk(btu_pkg::OFS_STATUS, 32'h0000_0000, 1'b0); // write ignored
		wr(btu_pkg::OFS_CTRL, 32'h0000_0005); // enable, continue
		repeat (4) @(posedge pclk);
		chk({31'h0, cont}, 32'h0000_0001); // continue taken while idle
		run_start <= 1'b1;
		run_prev_end <= 32'hA123_4560;
		run_start_addr <= 32'hB765_4320;
		@(posedge pclk);
		run_start <= 1'b0;
		rd_chk(btu_pkg::OFS_START_SRC, 32'h0123_4560, 1'b0); // previous end
		rd_chk(btu_pkg::OFS_START_DST, 32'h0765_4320, 1'b0); // start address
		// Each length code in turn against the sent references
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			branch(s_tab[i], d_tab[i]);
			br_valid <= 1'b0;
			wait_frames(16'(i + 1)); // frame received
			chk({28'h0, hdr}, {28'h0, h_tab[i]}); // length codes
			chk(a_dst, d_tab[i]); // destination
			chk(a_src, s_tab[i]); // source
			chk(a_insn, ~d_tab[i]); // destination word
		end
		// Back to back in non-realtime mode: stalls, nothing lost
		stalls = 0;
		@(posedge pclk);
		for (int i = 0; i < 6; i++) begin
			branch(32'hF000_0100 + 32'(i * 16), 32'hE000_0200 + 32'(i * 16));
		end
		br_valid <= 1'b0;
		wait_frames(16'h0009); // every record sent
		chk(32'(stalls != 0), 32'h0000_0001); // CPU held
		chk(a_dst, 32'hE000_0250); // last destination
		repeat (10) @(posedge pclk);
		rd_chk(btu_pkg::OFS_STATUS, 32'h0008_0008, 1'b0); // eight kept
		wr(btu_pkg::OFS_HIST_IDX, 32'h0000_0000); // newest slot
		rd_chk(btu_pkg::OFS_HIST_SRC, 32'h0000_0150, 1'b0); // newest
		rd_chk(btu_pkg::OFS_HIST_DST, 32'h0000_0250, 1'b0); // newest
		rd_chk(btu_pkg::OFS_HIST_INSN, 32'h1FFF_FDAF, 1'b0); // instruction
		wr(btu_pkg::OFS_HIST_IDX, 32'h0000_0007); // oldest slot
		rd_chk(btu_pkg::OFS_HIST_SRC, 32'h0000_1210, 1'b0); // oldest kept
		// Realtime, stop mode: no stalls, records dropped
		wr(btu_pkg::OFS_CTRL, 32'h0000_0003); // realtime, stop
		repeat (4) @(posedge pclk);
		chk({31'h0, cont}, 32'h0000_0000); // stop mode
		stalls = 0;
		@(posedge pclk);
		for (int i = 0; i < 6; i++) begin
			branch(32'h1000_0000 + 32'(i * 64), 32'h2000_0000 + 32'(i * 64));
		end
		br_valid <= 1'b0;
		repeat (100) @(posedge pclk);
		chk(32'(stalls), 32'h0000_0000); // CPU never held
		chk(a_dst, 32'h2000_0140); // newest record sent
		chk(32'(frames < 16'h000F), 32'h0000_0001); // some abandoned
		apb(1'b0, btu_pkg::OFS_STATUS, 32'h0000_0000, d, err_st); // status read
		chk({31'h0, err_st}, 32'h0000_0000); // status mapped
		chk(32'(d[15:8] != 8'h00), 32'h0000_0001); // drops counted
		chk({28'h0, d[3:0]}, 32'h0000_0004); // realtime stop reported
		close_out();
	end
endmodule

`default_nettype wire
